// File: src/auto_reclose_sequencer.sv
/*
  Auto-reclose sequencer for an overhead feeder breaker, with AXI4-Lite settings.
  Assumes request and breaker inputs are asynchronous pins; one 40 MHz clock.
*/
// Operation
// - Five requests, first highest, fifth lowest priority.
// - Critical request halts any sequence at once.
// - Close only after the dead time elapses.
// - Persisting fault takes further configured shots.
// - Final trip latches lockout blocking closing.
// - Setting selects arcing delay or protection time.
// - Refault in reclaim: next shot or final trip.
// - Lockout holds until cleared from outside.
`timescale 1ns/100ps
module auto_reclose_sequencer
  import arc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC // Cycles per timing tick, shortened in simulation.
) (
  input wire logic aclk, // System clock, 40 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic reclose_request_top, // Highest priority reclose request.
  input wire logic reclose_request_2, // Second request.
  input wire logic reclose_request_3, // Third request.
  input wire logic reclose_request_4, // Fourth request.
  input wire logic reclose_request_lowest, // Lowest priority reclose request.
  input wire logic critical_request, // Halts reclosing.
  input wire logic breaker_open, // Breaker open status.
  output logic close_cmd, // Breaker close command.
  output logic trip_cmd, // Breaker open command (arcing trip or final trip).
  output logic lockout, // Feeder locked.
  output logic [2:0] active_req, // Index 1..5 of the owning request, 0 if none.
  output logic irq, // Level interrupt.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready // Read data ready.
);
  initial begin
    if (TICK_CYCLES < 1) begin
      $error("TICK_CYCLES must be at least one");
    end
  end

  localparam int SYNC_W = N_REQ + 2;

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [N_REQ-1:0] req;
  logic crit;
  logic brk_open;
  logic [31:0] ctrl_r;
  logic [31:0] dead_r;
  logic [31:0] arc_r;
  logic [31:0] reclaim_r;
  logic lock_clr;
  logic [31:0] status;
  logic [IRQ_W-1:0] irq_set;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [31:0] time_r;
  logic [3:0] shot_r;
  logic [2:0] pick;
  logic enter;

  // Pins cross into the clock domain through two flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {breaker_open, critical_request, reclose_request_lowest, reclose_request_4,
                  reclose_request_3, reclose_request_2, reclose_request_top};
      sync2_r <= sync1_r;
    end
  end
  assign req = sync2_r[N_REQ-1:0];
  assign crit = sync2_r[N_REQ];
  assign brk_open = sync2_r[N_REQ+1];

  // Lowest index wins, so the first request outranks the rest.
  function automatic logic [2:0] prio(input logic [N_REQ-1:0] r);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = N_REQ - 1; i >= 0; i--) begin
      if (r[i]) begin
        idx = 3'(i + 1);
      end
    end
    return idx;
  endfunction : prio
  assign pick = prio(req);

  // Millisecond tick from a divider; all sequence timing counts ticks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= 32'h0;
    end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end
  assign tick = tick_cnt_r == 32'(TICK_CYCLES - 1);

  // Next state; the critical request and the enable bit override every state except idle and lockout.
  always_comb begin
    state_nxt = state_r;
    enter = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // A held critical request also keeps a new sequence from starting and bouncing.
        if (pick != 3'h0 && !crit && ctrl_r[CTRL_SHOTS_LSB +: 4] != 4'h0) begin
          state_nxt = ST_WAIT_OPEN;
          enter = 1'b1;
        end
      end
      ST_WAIT_OPEN: begin
        if (brk_open) begin
          state_nxt = ST_DEAD;
          enter = 1'b1;
        end
      end
      ST_DEAD: begin
        if (tick && time_r >= dead_r) begin
          state_nxt = ST_CLOSE;
          enter = 1'b1;
        end
      end
      ST_CLOSE: begin
        if (tick && time_r >= 32'(CLOSE_TICKS)) begin
          state_nxt = ST_RECLAIM;
          enter = 1'b1;
        end
      end
      ST_RECLAIM: begin
        if (pick != 3'h0 || brk_open) begin
          enter = 1'b1;
          if (ctrl_r[CTRL_REFAULT_TRIP] || shot_r >= ctrl_r[CTRL_SHOTS_LSB +: 4]) begin
            state_nxt = ST_LOCKED;
          end else if (ctrl_r[CTRL_ARC_EN]) begin
            state_nxt = ST_ARC;
          end else begin
            state_nxt = ST_WAIT_OPEN;
          end
        end else if (tick && time_r >= reclaim_r) begin
          state_nxt = ST_IDLE;
          enter = 1'b1;
        end
      end
      ST_ARC: begin
        if (tick && time_r >= arc_r) begin
          state_nxt = ST_WAIT_OPEN;
          enter = 1'b1;
        end
      end
      ST_LOCKED: begin
        if (lock_clr) begin
          state_nxt = ST_IDLE;
          enter = 1'b1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (state_r != ST_LOCKED && state_r != ST_IDLE && (crit || !ctrl_r[CTRL_ENABLE])) begin
      state_nxt = ST_IDLE;
      enter = 1'b1;
    end
  end

  // Sequence state, shot count and owning request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      shot_r <= 4'h0;
      active_req <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == ST_IDLE) begin
        shot_r <= 4'h0;
        active_req <= 3'h0;
      end else if (state_r == ST_IDLE) begin
        active_req <= pick;
      end
      if (state_nxt == ST_CLOSE && state_r != ST_CLOSE) begin
        shot_r <= shot_r + 4'h1;
      end
    end
  end

  // Phase timer restarts whenever a phase is entered.
  always_ff @(posedge aclk) begin
    if (!aresetn || enter) begin
      time_r <= 32'h0;
    end else if (tick) begin
      time_r <= time_r + 32'h1;
    end
  end

  // Breaker commands come from flops; no close while locked or before dead time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      close_cmd <= 1'b0;
      trip_cmd <= 1'b0;
      lockout <= 1'b0;
    end else begin
      close_cmd <= state_nxt == ST_CLOSE;
      trip_cmd <= state_nxt == ST_ARC || (state_nxt == ST_LOCKED && !brk_open);
      lockout <= state_nxt == ST_LOCKED;
    end
  end

  assign irq_set[IRQ_CLOSE] = state_nxt == ST_CLOSE && state_r != ST_CLOSE;
  assign irq_set[IRQ_TRIP] = state_nxt == ST_LOCKED && state_r != ST_LOCKED;
  assign irq_set[IRQ_LOCK] = state_r == ST_LOCKED && state_nxt == ST_IDLE;
  assign irq_set[IRQ_HALT] = crit && state_r != ST_IDLE && state_r != ST_LOCKED;
  assign status = {16'h0, active_req, shot_r, lockout, state_r, brk_open, crit, close_cmd,
                   trip_cmd, 1'b0};

  arc_axil u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .ctrl_r(ctrl_r),
    .dead_r(dead_r),
    .arc_r(arc_r),
    .reclaim_r(reclaim_r),
    .lock_clr(lock_clr),
    .status(status),
    .irq_set(irq_set),
    .irq(irq)
  );

  // The critical request returns the sequence to idle on the next edge.
  property p_crit_halt;
    @(posedge aclk) disable iff (!aresetn)
      crit && state_r != ST_IDLE && state_r != ST_LOCKED |=> state_r == ST_IDLE;
  endproperty
  a_crit_halt: assert property (p_crit_halt) else $error("critical request did not halt");

  // No close command while locked out.
  property p_no_close_locked;
    @(posedge aclk) disable iff (!aresetn) lockout |-> !close_cmd;
  endproperty
  a_no_close_locked: assert property (p_no_close_locked) else $error("close while locked");

  // Close only follows the dead phase.
  property p_close_after_dead;
    @(posedge aclk) disable iff (!aresetn)
      $rose(close_cmd) |-> $past(state_r) == ST_DEAD;
  endproperty
  a_close_after_dead: assert property (p_close_after_dead) else $error("close without dead");

  // Dead time starts only with the breaker seen open.
  property p_dead_on_open;
    @(posedge aclk) disable iff (!aresetn)
      state_r == ST_WAIT_OPEN && !brk_open |=> state_r != ST_DEAD;
  endproperty
  a_dead_on_open: assert property (p_dead_on_open) else $error("dead time before open");

  // Lockout persists until a clear pulse arrives.
  property p_lock_hold;
    @(posedge aclk) disable iff (!aresetn)
      state_r == ST_LOCKED && !lock_clr |=> state_r == ST_LOCKED;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout released early");

  // Highest priority request owns the sequence.
  property p_prio;
    @(posedge aclk) disable iff (!aresetn)
      state_r == ST_IDLE && req[0] && state_nxt == ST_WAIT_OPEN |=> active_req == 3'h1;
  endproperty
  a_prio: assert property (p_prio) else $error("wrong request owner");

  // Refault with trip setting goes straight to lockout.
  property p_refault_trip;
    @(posedge aclk) disable iff (!aresetn)
      state_r == ST_RECLAIM && pick != 3'h0 && ctrl_r[CTRL_REFAULT_TRIP] && !crit
      && ctrl_r[CTRL_ENABLE] |=> lockout;
  endproperty
  a_refault_trip: assert property (p_refault_trip) else $error("refault did not lock");

  // Arcing phase only when the arcing setting is on.
  property p_arc_sel;
    @(posedge aclk) disable iff (!aresetn)
      state_r == ST_ARC |-> ctrl_r[CTRL_ARC_EN];
  endproperty
  a_arc_sel: assert property (p_arc_sel) else $error("arcing phase while disabled");

  // Shot count never exceeds the configured number.
  property p_shot_limit;
    @(posedge aclk) disable iff (!aresetn)
      shot_r <= ctrl_r[CTRL_SHOTS_LSB +: 4] || $changed(ctrl_r);
  endproperty
  a_shot_limit: assert property (p_shot_limit) else $error("too many shots");
endmodule : auto_reclose_sequencer

// File: src/arc_pkg.sv
/*
  Constants shared by the auto-reclose sequencer and its register slave.
  Assumes a 40 MHz system clock and an AXI4-Lite master with 32-bit data.
*/
package arc_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int N_REQ = 5;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DEAD = 8'h04;
  localparam logic [7:0] OFF_ARC = 8'h08;
  localparam logic [7:0] OFF_RECLAIM = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // Control register fields.
  localparam int CTRL_SHOTS_LSB = 0;
  localparam int CTRL_ARC_EN = 4;
  localparam int CTRL_REFAULT_TRIP = 5;
  localparam int CTRL_ENABLE = 6;
  localparam int CTRL_LOCK_CLR = 7;
  // Reset values; times are counted in 1 ms ticks.
  localparam logic [31:0] CTRL_RST = 32'h0000_0042;
  localparam logic [31:0] DEAD_RST = 32'h0000_00c8;
  localparam logic [31:0] ARC_RST = 32'h0000_00c8;
  localparam logic [31:0] RECLAIM_RST = 32'h0000_2710;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int CLOSE_TICKS = 4; // Ticks the close command stands.
  // Interrupt status bits.
  localparam int IRQ_CLOSE = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_LOCK = 2;
  localparam int IRQ_HALT = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_OPEN, ST_DEAD, ST_CLOSE, ST_RECLAIM, ST_ARC, ST_LOCKED
  } seq_state_t;
endpackage : arc_pkg

// File: src/arc_axil.sv
/*
  AXI4-Lite slave holding the sequencer's settings and interrupt registers.
  Assumes one master on the same clock; one write and one read at a time.
*/
`timescale 1ns/100ps
module arc_axil
  import arc_pkg::*;
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output logic [31:0] ctrl_r, // Control register.
  output logic [31:0] dead_r, // Dead time in ticks.
  output logic [31:0] arc_r, // Arcing time in ticks.
  output logic [31:0] reclaim_r, // Reclaim time in ticks.
  output logic lock_clr, // One-cycle lockout clear pulse.
  input wire logic [31:0] status, // Live sequencer status.
  input wire logic [IRQ_W-1:0] irq_set, // Event pulses.
  output logic irq // Level interrupt.
);
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] mask_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  assign awready = !aw_hold_r && !bvalid;
  assign wready = !w_hold_r && !bvalid;
  assign do_wr = aw_hold_r && w_hold_r && !bvalid;
  assign bresp = 2'h0;
  assign arready = !rvalid;
  assign irq = |(stat_r & mask_r);
  assign lock_clr = do_wr && awaddr_r == OFF_CTRL && wstrb_r[0] && wdata_r[CTRL_LOCK_CLR];

  // Address and data are latched independently so either may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid <= 1'b1;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Settings registers; the lockout clear bit is a pulse and is not stored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      dead_r <= DEAD_RST;
      arc_r <= ARC_RST;
      reclaim_r <= RECLAIM_RST;
      mask_r <= '0;
    end else if (do_wr) begin
      case (awaddr_r)
        OFF_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_007f;
        OFF_DEAD: dead_r <= merge(dead_r, wdata_r, wstrb_r);
        OFF_ARC: arc_r <= merge(arc_r, wdata_r, wstrb_r);
        OFF_RECLAIM: reclaim_r <= merge(reclaim_r, wdata_r, wstrb_r);
        OFF_IRQ_MASK: mask_r <= wstrb_r[0] ? wdata_r[IRQ_W-1:0] : mask_r;
        default: ;
      endcase
    end
  end

  // Sticky events: a set arriving with a write-one clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= '0;
    end else begin
      if (do_wr && awaddr_r == OFF_IRQ_STAT && wstrb_r[0]) begin
        stat_r <= (stat_r & ~wdata_r[IRQ_W-1:0]) | irq_set;
      end else begin
        stat_r <= stat_r | irq_set;
      end
    end
  end

  // Reads answer one cycle after the address; unmapped offsets read zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= 2'h0;
      case (araddr)
        OFF_CTRL: rdata <= ctrl_r;
        OFF_DEAD: rdata <= dead_r;
        OFF_ARC: rdata <= arc_r;
        OFF_RECLAIM: rdata <= reclaim_r;
        OFF_STATUS: rdata <= status;
        OFF_IRQ_STAT: rdata <= {{(32-IRQ_W){1'b0}}, stat_r};
        OFF_IRQ_MASK: rdata <= {{(32-IRQ_W){1'b0}}, mask_r};
        default: rdata <= 32'h0;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : arc_axil

// File: test/breaker_model.sv
/*
  Breaker and protection stand-in for the auto-reclose bench.
  Assumes the bench drives the protection trip and the operator close by NBA.
*/
`timescale 1ns/100ps
module breaker_model #(
  parameter int OP_CYC = 3 // Contact travel in cycles.
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic close_cmd, // Close order from the sequencer.
  input wire logic trip_cmd, // Open order from the sequencer.
  input wire logic prot_trip, // Protection trip, opens the breaker directly.
  input wire logic man_close, // Operator close once the feeder is released.
  input wire logic slow, // Slow opening mechanism.
  output logic breaker_open // High while the contacts are apart.
);
  logic [7:0] cnt_r;
  logic tgt_r;
  // Status changes only after the contacts have travelled; an open order beats a close.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 8'h00;
      tgt_r <= 1'b0;
      breaker_open <= 1'b0;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01) begin
        breaker_open <= tgt_r;
      end
    end else if ((trip_cmd || prot_trip) && !breaker_open) begin
      cnt_r <= slow ? 8'h14 : 8'(OP_CYC);
      tgt_r <= 1'b1;
    end else if ((close_cmd || man_close) && breaker_open && !trip_cmd) begin
      cnt_r <= 8'(OP_CYC);
      tgt_r <= 1'b0;
    end
  end
endmodule : breaker_model

// File: test/tb.sv
/*
  Self-checking bench for the auto-reclose sequencer.
  Assumes a shortened timing tick and the breaker model beside the design.
*/
`timescale 1ns/100ps
module tb
  import arc_pkg::*;
;
  localparam int TK = 4;
  localparam int DEAD = 3;
  localparam int ARC = 2;
  localparam int RECL = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] req = 5'h00;
  logic critical_request = 1'b0;
  logic prot_trip = 1'b0;
  logic man_close = 1'b0;
  logic slow = 1'b0;
  logic breaker_open, close_cmd, trip_cmd, lockout, irq;
  logic [2:0] active_req;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int n;

  auto_reclose_sequencer #(.TICK_CYCLES(TK)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .reclose_request_top(req[0]),
    .reclose_request_2(req[1]), .reclose_request_3(req[2]), .reclose_request_4(req[3]),
    .reclose_request_lowest(req[4]), .critical_request(critical_request),
    .breaker_open(breaker_open), .close_cmd(close_cmd), .trip_cmd(trip_cmd),
    .lockout(lockout), .active_req(active_req), .irq(irq),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1));

  breaker_model brk_u (
    .aclk(aclk), .aresetn(aresetn), .close_cmd(close_cmd), .trip_cmd(trip_cmd),
    .prot_trip(prot_trip), .man_close(man_close), .slow(slow),
    .breaker_open(breaker_open));

  // Clock, and a hang guard far above the several hundred cycles the run needs.
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Both write halves go out together; bready is held high so the answer is never lost.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    @(posedge aclk iff bvalid);
    chk("bresp", 32'h0, 32'(bresp));
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk iff arready);
    arvalid <= 1'b0;
    @(posedge aclk iff rvalid);
    v = rdata;
    chk("rresp", 32'h0, 32'(rresp));
  endtask : axi_rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi_rd(a, d);
    chk(nm, e, d);
  endtask : rdc

  // A fault opens the breaker; returns the cycles from open status to the close order.
  task automatic shot(input logic [4:0] r, output int dn);
    req <= r;
    prot_trip <= 1'b1;
    @(posedge aclk iff breaker_open);
    req <= 5'h00;
    prot_trip <= 1'b0;
    dn = 0;
    while (close_cmd !== 1'b1) begin
      @(posedge aclk);
      dn++;
    end
    @(posedge aclk iff !close_cmd);
  endtask : shot

  // A request keeps coming for k cycles; the close order must stay low throughout.
  task automatic no_close(input int k, input string nm);
    int bad;
    bad = 0;
    req <= 5'h01;
    repeat (k) begin
      @(posedge aclk);
      if (close_cmd !== 1'b0) bad++;
    end
    req <= 5'h00;
    chk(nm, 0, bad);
  endtask : no_close

  // Lockout must hold off closing until software clears it, then the operator recloses.
  task automatic lock_check(input logic [31:0] c);
    @(posedge aclk iff lockout === 1'b1);
    prot_trip <= 1'b0;
    axi_rd(OFF_STATUS, d);
    chk("status lock bit", 1, d[8]);
    no_close(60, "close in lockout");
    chk("lock held", 1, lockout);
    axi_wr(OFF_CTRL, c | 32'h0000_0080);
    repeat (3) @(posedge aclk);
    chk("lock cleared", 0, lockout);
    rdc(OFF_CTRL, c, "clear bit not stored");
    man_close <= 1'b1;
    @(posedge aclk iff !breaker_open);
    man_close <= 1'b0;
  endtask : lock_check

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(OFF_CTRL, CTRL_RST, "ctrl reset");
    rdc(OFF_DEAD, DEAD_RST, "dead reset");
    rdc(OFF_ARC, ARC_RST, "arc reset");
    rdc(OFF_RECLAIM, RECLAIM_RST, "reclaim reset");
    rdc(OFF_STATUS, 32'h0000_0000, "status reset");
    rdc(OFF_IRQ_MASK, 32'h0000_0000, "mask reset");
    axi_wr(8'h1c, 32'hffff_ffff);
    rdc(8'h1c, 32'h0000_0000, "unmapped read");
    axi_wr(OFF_DEAD, 32'(DEAD));
    axi_wr(OFF_ARC, 32'(ARC));
    axi_wr(OFF_RECLAIM, 32'(RECL));
    // Every request set alongside all lower ones; the highest wins, critical halts it.
    for (int i = 0; i < 5; i++) begin
      req <= 5'(5'h1f << i);
      @(posedge aclk iff active_req !== 3'h0);
      chk("owner", i + 1, active_req);
      critical_request <= 1'b1;
      n = 0;
      while (active_req !== 3'h0) begin
        @(posedge aclk);
        n++;
      end
      chk("halt delay", 1, n <= 4);
      req <= 5'h00;
      repeat (4) @(posedge aclk);
      critical_request <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    // Halt events were recorded but masked; unmask, then clear by writing one.
    chk("irq masked", 0, irq);
    rdc(OFF_IRQ_STAT, 32'h0000_0008, "halt event");
    axi_wr(OFF_IRQ_MASK, 32'h0000_000f);
    chk("irq raised", 1, irq);
    axi_wr(OFF_IRQ_STAT, 32'h0000_0008);
    chk("irq cleared", 0, irq);
    // Two shots, then a refault with the shots spent ends in lockout.
    shot(5'h01, n);
    chk("dead span 1", 1, n >= DEAD * TK && n <= (DEAD + 1) * TK + 4);
    shot(5'h01, n);
    chk("dead span 2", 1, n >= DEAD * TK && n <= (DEAD + 1) * TK + 4);
    req <= 5'h01;
    prot_trip <= 1'b1;
    lock_check(32'h0000_0042);
    rdc(OFF_IRQ_STAT, 32'h0000_0007, "close lock clear events");
    axi_wr(OFF_IRQ_STAT, 32'h0000_000f);
    // Refault set to final trip, slow breaker; first a quiet reclaim returns to idle.
    axi_wr(OFF_CTRL, 32'h0000_0062);
    slow <= 1'b1;
    shot(5'h01, n);
    chk("dead span slow", 1, n >= DEAD * TK && n <= (DEAD + 1) * TK + 4);
    n = 0;
    while (active_req !== 3'h0) begin
      @(posedge aclk);
      n++;
    end
    chk("reclaim span", 1, n >= RECL * TK - 8 && n <= (RECL + 1) * TK + 4);
    shot(5'h02, n);
    req <= 5'h02;
    prot_trip <= 1'b1;
    lock_check(32'h0000_0062);
    slow <= 1'b0;
    // Arcing delay: the refault is answered by a timed trip before the next shot.
    axi_wr(OFF_CTRL, 32'h0000_0052);
    shot(5'h01, n);
    req <= 5'h01;
    @(posedge aclk iff trip_cmd === 1'b1);
    req <= 5'h00;
    n = 0;
    while (trip_cmd !== 1'b0) begin
      @(posedge aclk);
      n++;
    end
    chk("arc span", 1, n >= ARC * TK && n <= (ARC + 1) * TK + 2);
    critical_request <= 1'b1;
    @(posedge aclk iff active_req === 3'h0);
    no_close(40, "close after halt");
    critical_request <= 1'b0;
    man_close <= 1'b1;
    @(posedge aclk iff !breaker_open);
    man_close <= 1'b0;
    conclude();
  end
endmodule : tb
